// >>> shared/cml_pkg.sv
// package: constants, opcodes, register map for the move/logic/return core slice
package cml_pkg;

    // ****************************************
    // instruction encoding (14-bit word)
    // ****************************************
    localparam int INSTR_W = 14;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int DEST_BIT = 7;

    localparam logic [5:0] OP_INCREMENT_FILE = 6'h0A;
    localparam logic [5:0] OP_OR_WITH_FILE = 6'h04;
    localparam logic [5:0] OP_MOVE_FILE = 6'h08;
    localparam logic [5:0] OP_ZERO_GROUP = 6'h00;
    localparam logic [5:0] OP_ROTATE_LEFT = 6'h0D;
    localparam logic [3:0] OP_LOAD_LITERAL = 4'hC;
    localparam logic [3:0] OP_RETURN_LITERAL = 4'hD;
    localparam logic [13:0] OP_NO_OPERATION = 14'h0000;
    localparam logic [13:0] OP_RETURN_INTERRUPT = 14'h0009;

    // ****************************************
    // register map (AXI4-Lite byte offsets)
    // ****************************************
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_INSTR = 8'h04;
    localparam logic [7:0] REG_WORKING = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_FILE_ADDR = 8'h14;
    localparam logic [7:0] REG_FILE_DATA = 8'h18;

    localparam int STAT_ZERO = 0;
    localparam int STAT_CARRY = 1;
    localparam int STAT_INT_ENABLE = 2;
    localparam int STAT_ILLEGAL = 3;

    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : cml_pkg

// >>> rtl/cml_alu.sv
// alu: result and flag values for the covered byte operations
`timescale 1ns/1ns
`default_nettype none
module cml_alu
    import cml_pkg::*;
(
    // operands
    input wire logic [5:0] opcode,
    input wire logic [7:0] fileVal,
    input wire logic [7:0] workVal,
    input wire logic carryIn,
    // results
    output logic [7:0] result,
    output logic carryOut,
    output logic zeroOut
);
    always_comb
    begin
        result = fileVal;
        carryOut = carryIn;
        unique case (opcode)
            OP_INCREMENT_FILE: result = fileVal + 8'h01;  // [RULE_02]
            OP_OR_WITH_FILE: result = workVal | fileVal;  // [RULE_03]
            OP_ROTATE_LEFT:
            begin
                result = {fileVal[6:0], carryIn};  // [RULE_09] [RULE_10]
                carryOut = fileVal[7];  // [RULE_10]
            end
            default: result = fileVal;  // [RULE_04]
        endcase
        zeroOut = (result == 8'h00);
    end
endmodule : cml_alu
`default_nettype wire

// >>> rtl/cml_core.sv
// core slice: executes the covered instructions, registers on AXI4-Lite
//
// What this block does
// [RULE_01] A file-op result goes to the working register when d is 0, else back to the file.
// [RULE_02] Increment-file adds one to the addressed file and updates the zero flag.
// [RULE_03] Or-with-file ORs working and file, zero flag set only on a zero result.
// [RULE_04] Move-file copies the file to the destination and updates the zero flag.
// [RULE_05] Load-literal puts the 8-bit literal in the working register, flags untouched.
// [RULE_06] Return-from-interrupt pops the stack into the pc and sets the interrupt enable.
// [RULE_07] Store-working writes the working register into the addressed file, no flags.
// [RULE_08] Return-with-literal loads the literal into working and pops the stack into the pc.
// [RULE_09] Rotate-left shifts the file left through carry to the destination.
// [RULE_10] In a rotate-left old bit 7 enters carry and old carry enters bit 0.
// [RULE_11] No-operation changes nothing except advancing the pc.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cml_core
    import cml_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // reset synchroniser
    // ****************************************
    logic rstMeta_q, rstSync_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            {rstMeta_q, rstSync_q} <= 2'b00;
        else
            {rstSync_q, rstMeta_q} <= {rstMeta_q, 1'b1};
    end
    // ****************************************
    // architectural state
    // ****************************************
    logic [7:0] fileMem [0:(1 << ADDR_W) - 1];
    logic [12:0] stackMem [0:STACK_DEPTH - 1];
    logic [7:0] work_q, work_d;
    logic [12:0] pc_q, pc_d;
    logic [2:0] sp_q, sp_d;
    logic zero_q, zero_d, carry_q, carry_d, intEnable_q, intEnable_d, illegal_q, illegal_d;
    logic [6:0] fileAddr_q, fileAddr_d;
    // bus-side handshake state
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d, rValid_q, rValid_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rData_q, rData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
    // ****************************************
    // decode and execute
    // ****************************************
    logic doWrite, execute, destFile, aluCarry, aluZero, fileWe, pushNone;
    logic [13:0] instr;
    logic [6:0] fAddr, fileWa;
    logic [7:0] fileVal, aluResult, fileWd;
    assign doWrite = awHeld_q && wHeld_q && !bValid_q;
    assign execute = doWrite && (awAddr_q == REG_INSTR) && (&wStrb_q[1:0]);
    assign instr = wData_q[13:0];
    assign fAddr = instr[6:0];
    assign destFile = instr[DEST_BIT];
    assign fileVal = fileMem[fAddr];
    assign pushNone = 1'b0;
    cml_alu uAlu (
        .opcode(instr[13:8]),
        .fileVal(fileVal),
        .workVal(work_q),
        .carryIn(carry_q),
        .result(aluResult),
        .carryOut(aluCarry),
        .zeroOut(aluZero)
    );
    always_comb
    begin
        work_d = work_q;
        pc_d = pc_q;
        sp_d = sp_q;
        zero_d = zero_q;
        carry_d = carry_q;
        intEnable_d = intEnable_q;
        illegal_d = illegal_q;
        fileAddr_d = fileAddr_q;
        fileWe = 1'b0;
        fileWa = fAddr;
        fileWd = aluResult;
        if (execute)
        begin
            pc_d = pc_q + 13'h0001;  // [RULE_11]
            if (instr == OP_RETURN_INTERRUPT)
            begin
                sp_d = sp_q - 3'h1;
                pc_d = stackMem[sp_q - 3'h1];  // [RULE_06]
                intEnable_d = 1'b1;  // [RULE_06]
            end
            else if (instr[13:10] == OP_LOAD_LITERAL)
                work_d = instr[7:0];  // [RULE_05]
            else if (instr[13:10] == OP_RETURN_LITERAL)
            begin
                work_d = instr[7:0];  // [RULE_08]
                sp_d = sp_q - 3'h1;
                pc_d = stackMem[sp_q - 3'h1];  // [RULE_08]
            end
            else if (instr[13:8] == OP_ZERO_GROUP && destFile)
            begin
                fileWe = 1'b1;  // [RULE_07]
                fileWd = work_q;  // [RULE_07]
            end
            else if (instr[13:8] == OP_INCREMENT_FILE || instr[13:8] == OP_OR_WITH_FILE
                     || instr[13:8] == OP_MOVE_FILE || instr[13:8] == OP_ROTATE_LEFT)
            begin
                fileWe = destFile;  // [RULE_01] [RULE_04]
                if (!destFile)
                    work_d = aluResult;  // [RULE_01]
                if (instr[13:8] == OP_ROTATE_LEFT)
                    carry_d = aluCarry;  // [RULE_10]
                else
                    zero_d = aluZero;  // [RULE_02] [RULE_03] [RULE_04]
            end
            else if (instr != OP_NO_OPERATION)  // no-operation only steps the pc [RULE_11]
                illegal_d = 1'b1;
        end
        else if (doWrite)
        begin
            if (awAddr_q == REG_FILE_ADDR && wStrb_q[0])
                fileAddr_d = wData_q[6:0];
            if (awAddr_q == REG_FILE_DATA && wStrb_q[0])
            begin
                fileWe = 1'b1;
                fileWa = fileAddr_q;
                fileWd = wData_q[7:0];
            end
            if (awAddr_q == REG_CONTROL && wStrb_q[0])
            begin
                intEnable_d = wData_q[STAT_INT_ENABLE];
                illegal_d = illegal_q & ~wData_q[STAT_ILLEGAL];
                carry_d = wData_q[STAT_CARRY];
                zero_d = wData_q[STAT_ZERO];
            end
        end
    end
    always_ff @(posedge clk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            work_q <= WORKING_RESET;
            pc_q <= PC_RESET;
            sp_q <= 3'h0;
            zero_q <= 1'b0;
            carry_q <= 1'b0;
            intEnable_q <= 1'b0;
            illegal_q <= 1'b0;
            fileAddr_q <= 7'h00;
        end
        else
        begin
            work_q <= work_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            zero_q <= zero_d;
            carry_q <= carry_d;
            intEnable_q <= intEnable_d;
            illegal_q <= illegal_d;
            fileAddr_q <= fileAddr_d;
        end
    end
    // file memory: no reset, written only on an enabled cycle
    always_ff @(posedge clk)
    begin
        if (fileWe)
            fileMem[fileWa] <= fileWd;
    end

    // return stack: no push path here, so every entry starts at the reset pc
    always_ff @(posedge clk or negedge rstSync_q)
    begin
        if (!rstSync_q)
            stackMem <= '{default: PC_RESET};
        else if (pushNone)
            stackMem[sp_q] <= pc_q;
    end
    // ****************************************
    // axi4-lite slave
    // ****************************************
    function automatic logic known(input logic [7:0] a);
        known = (a == REG_CONTROL) || (a == REG_INSTR) || (a == REG_WORKING)
            || (a == REG_STATUS) || (a == REG_PC) || (a == REG_FILE_ADDR)
            || (a == REG_FILE_DATA);
    endfunction : known
    always_comb
    begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_d = 1'b1;
            awAddr_d = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (doWrite)
        begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = known(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bValid_q && s_axi_bready)
            bValid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rValid_d = 1'b1;
            rResp_d = known({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
            unique case ({s_axi_araddr[7:2], 2'b00})
                REG_WORKING: rData_d = {24'h00_0000, work_q};
                REG_STATUS, REG_CONTROL:
                    rData_d = {28'h000_0000, illegal_q, intEnable_q, carry_q, zero_q};
                REG_PC: rData_d = {19'h0_0000, pc_q};
                REG_FILE_ADDR: rData_d = {25'h000_0000, fileAddr_q};
                REG_FILE_DATA: rData_d = {24'h00_0000, fileMem[fileAddr_q]};
                default: rData_d = 32'h0000_0000;
            endcase
        end
        else if (rValid_q && s_axi_rready)
            rValid_d = 1'b0;
    end
    always_ff @(posedge clk or negedge rstSync_q)
    begin
        if (!rstSync_q)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
            rValid_q <= 1'b0;
            rData_q <= 32'h0000_0000;
            rResp_q <= RESP_OKAY;
        end
        else
        begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end
    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
endmodule : cml_core
`default_nettype wire

// >>> verif/cml_core_monitor.sv
// checker: register port timing of the core slice
`timescale 1ns/1ns
`default_nettype none
module cml_core_monitor
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read side
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
        else $error("read data changed while waiting");
    a_ar_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_ar_block: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_w_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_b_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two edges after request");
    a_b_cause: assert property (
        $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write response without both halves");
    a_r_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
endmodule : cml_core_monitor
`default_nettype wire

// >>> verif/tb_cml_core.sv
// testbench: executes the covered instructions over the register port
`timescale 1ns/1ns
`default_nettype none
module tb_cml_core;
    import cml_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int pcCount = 0;
    logic [31:0] rdata_v;
    logic [1:0] resp_v;

    always #5 clk = ~clk;

    cml_core u_dut (.*);

    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tmo(input int n);
        if (n >= 50)
        begin
            failures++;
            $display("unexpected at %0t: handshake timed out", $time);
            end_sim();
        end
    endtask : tmo

    // ****************************************
    // bus cycles
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        bit hA;
        bit hW;
        int n;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !(aw && w); n++)
        begin
            @(negedge clk);
            hA = !aw && s_axi_awready === 1'b1;
            hW = !w && s_axi_wready === 1'b1;
            @(posedge clk);
            if (hA)
                s_axi_awvalid <= 1'b0;
            if (hW)
                s_axi_wvalid <= 1'b0;
            aw = aw | hA;
            w = w | hW;
        end
        tmo(n);
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk);
            if (s_axi_bvalid === 1'b1)
                break;
        end
        tmo(n);
        resp_v = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk);
            if (s_axi_arready === 1'b1)
                break;
        end
        tmo(n);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk);
            if (s_axi_rvalid === 1'b1)
                break;
        end
        tmo(n);
        rdata_v = s_axi_rdata;
        resp_v = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(rdata_v, {24'h00_0000, e});
    endtask : rdc

    task automatic ex(input logic [13:0] i);
        wr(REG_INSTR, {18'h0_0000, i});
        pcCount++;
    endtask : ex

    function automatic logic [13:0] fop(input logic [5:0] o, input logic dd);
        return {o, dd, 7'h7F};
    endfunction : fop

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(REG_WORKING, 8'h00);
        rdc(REG_STATUS, 8'h00);
        rdc(REG_PC, 8'h00);
        wr(REG_CONTROL, 32'h0000_0002);
        wr(REG_FILE_ADDR, 32'h0000_007F);
        rdc(REG_FILE_ADDR, 8'h7F);
        ex({OP_LOAD_LITERAL, 2'b00, 8'h00});
        rdc(REG_WORKING, 8'h00);
        rdc(REG_STATUS, 8'h02);
        ex({OP_LOAD_LITERAL, 2'b00, 8'hFF});
        rdc(REG_WORKING, 8'hFF);
        ex(fop(OP_ZERO_GROUP, 1'b1));
        rdc(REG_FILE_DATA, 8'hFF);
        rdc(REG_STATUS, 8'h02);
        ex(fop(OP_INCREMENT_FILE, 1'b0));
        rdc(REG_WORKING, 8'h00);
        rdc(REG_FILE_DATA, 8'hFF);
        rdc(REG_STATUS, 8'h03);
        ex({OP_LOAD_LITERAL, 2'b00, 8'h11});
        wr(REG_FILE_DATA, 32'h0000_0041);
        ex(fop(OP_INCREMENT_FILE, 1'b1));
        rdc(REG_FILE_DATA, 8'h42);
        rdc(REG_STATUS, 8'h02);
        ex(fop(OP_OR_WITH_FILE, 1'b1));
        rdc(REG_FILE_DATA, 8'h53);
        rdc(REG_WORKING, 8'h11);
        wr(REG_FILE_DATA, 32'h0000_0000);
        ex({OP_LOAD_LITERAL, 2'b00, 8'h00});
        ex(fop(OP_OR_WITH_FILE, 1'b0));
        rdc(REG_STATUS, 8'h03);
        wr(REG_CONTROL, 32'h0000_0002);
        ex(fop(OP_MOVE_FILE, 1'b1));
        rdc(REG_STATUS, 8'h03);
        rdc(REG_FILE_DATA, 8'h00);
        wr(REG_FILE_DATA, 32'h0000_0091);
        ex(fop(OP_MOVE_FILE, 1'b0));
        rdc(REG_WORKING, 8'h91);
        rdc(REG_STATUS, 8'h02);
        wr(REG_FILE_DATA, 32'h0000_0080);
        ex(fop(OP_ROTATE_LEFT, 1'b0));
        rdc(REG_WORKING, 8'h01);
        rdc(REG_FILE_DATA, 8'h80);
        rdc(REG_STATUS, 8'h02);
        wr(REG_CONTROL, 32'h0000_0000);
        wr(REG_FILE_DATA, 32'h0000_00C0);
        ex(fop(OP_ROTATE_LEFT, 1'b1));
        rdc(REG_FILE_DATA, 8'h80);
        rdc(REG_STATUS, 8'h02);
        ex(OP_NO_OPERATION);
        rdc(REG_WORKING, 8'h01);
        rdc(REG_FILE_DATA, 8'h80);
        rdc(REG_STATUS, 8'h02);
        rdc(REG_PC, 8'(pcCount));
        wr(REG_CONTROL, 32'h0000_0001);
        ex({OP_RETURN_LITERAL, 2'b00, 8'h3C});
        rdc(REG_WORKING, 8'h3C);
        rdc(REG_STATUS, 8'h01);
        rdc(REG_PC, 8'h00);
        ex(OP_RETURN_INTERRUPT);
        rdc(REG_STATUS, 8'h05);
        rdc(REG_PC, 8'h00);
        ex(14'h0001);
        rdc(REG_STATUS, 8'h0D);
        wr(REG_CONTROL, 32'h0000_000D);
        rdc(REG_STATUS, 8'h05);
        wr(8'h40, 32'h0000_00FF);
        chk(32'(resp_v), 32'(RESP_SLVERR));
        rd(8'h40);
        chk(rdata_v, 32'h0000_0000);
        chk(32'(resp_v), 32'(RESP_SLVERR));
        rdc(REG_WORKING, 8'h3C);
        end_sim();
    end
endmodule : tb_cml_core

bind cml_core cml_core_monitor u_mon (.*);
`default_nettype wire
